/* File: logic/osc_config_decode.sv */
// Decodes the oscillator selection and configuration words into clock
// controls. Assumes the words come straight from configuration memory
// and hold still while the device runs; erased bits read as one.
`timescale 1ns/100ps
`include "osc_cfg_defs.svh"
module osc_config_decode import osc_cfg_pkg::*; (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic [7:0] SEL_WORD_IN,
  input wire logic [7:0] CFG_WORD_IN,
  output logic [7:0] SEL_WORD_READ,
  output logic [7:0] CFG_WORD_READ,
  output logic CONFIG_VALID,
  output logic TWO_SPEED_SWITCHOVER_EN,
  output logic SLOW_RC_POWER_SELECT,
  output logic SECONDARY_CRYSTAL_EN,
  output logic SECONDARY_DIGITAL_CLOCK_IN_EN,
  output logic [2:0] STARTUP_SOURCE_FIELD,
  output logic USE_PLL,
  output logic USE_POSTSCALER,
  output logic CLOCK_SWITCH_EN,
  output logic FAIL_SAFE_MONITOR_EN,
  output logic SECONDARY_POWER_SELECT,
  output logic [1:0] PRIMARY_RANGE_FIELD,
  output logic RANGE_RESERVED_SEEN,
  output logic CLOCK_OUTPUT_EN,
  output logic PRIMARY_OSC_EN,
  output logic HIGH_SPEED_CRYSTAL_MODE,
  output logic STANDARD_CRYSTAL_MODE,
  output logic EXTERNAL_CLOCK_MODE
);
  // ***********************************************************
  // Capture
  // ***********************************************************
  osc_words_if words ();
  logic captured;

  // Words enter through table accesses upstream
  osc_word_capture u_capture (
    .ref_clk(REF_CLK),
    .arst_n(ARST_N),
    .sel_in(SEL_WORD_IN),
    .cfg_in(CFG_WORD_IN),
    .captured(captured),
    .words(words)
  );

  // ***********************************************************
  // Decode state
  // ***********************************************************
  typedef struct packed {
    logic valid;
    logic switchover;
    logic slow_rc_pwr;
    logic sec_crystal;
    logic [2:0] src;
    logic pll;
    logic postscale;
    logic clk_switch;
    logic monitor;
    logic sec_power;
    logic [1:0] range;
    logic reserved;
    logic clk_out;
    logic pri_en;
    logic hs;
    logic xt;
    logic ec;
  } dec_t;
  dec_t q;
  dec_t next_q;

  function automatic logic bit_of(input logic [7:0] w, input int pos);
    bit_of = w[pos];
  endfunction

  logic [7:0] sw;
  logic [7:0] cw;
  logic [1:0] pmode;
  logic [1:0] mon;
  assign sw = words.sel_word;
  assign cw = words.cfg_word;
  assign pmode = cw[`CFG_PRIMARY_LSB +: 2];
  assign mon = cw[`CFG_MONITOR_LSB +: 2];

  always_comb begin
    next_q = q;
    next_q.valid = captured;
    next_q.switchover = bit_of(sw, `SEL_SWITCHOVER_BIT);
    next_q.slow_rc_pwr = bit_of(sw, `SEL_SLOW_RC_PWR_BIT);
    next_q.sec_crystal = bit_of(sw, `SEL_SEC_SOURCE_BIT);
    next_q.src = sw[`SEL_STARTUP_LSB +: 3];
    case (startup_src_t'(sw[`SEL_STARTUP_LSB +: 3]))
      SRC_FAST_RC: begin
        next_q.pll = 1'b0;
        next_q.postscale = 1'b0;
      end
      SRC_FAST_RC_DIV_PLL: begin
        next_q.pll = 1'b1;
        next_q.postscale = 1'b1;
      end
      SRC_PRIMARY: begin
        next_q.pll = 1'b0;
        next_q.postscale = 1'b0;
      end
      SRC_PRIMARY_PLL: begin
        next_q.pll = 1'b1;
        next_q.postscale = 1'b0;
      end
      SRC_SECONDARY, SRC_SLOW_RC: begin
        next_q.pll = 1'b0;
        next_q.postscale = 1'b0;
      end
      SRC_LP_FAST_RC_DIV: begin
        next_q.pll = 1'b0;
        next_q.postscale = 1'b1;
      end
      default: begin
        next_q.pll = 1'b0;
        next_q.postscale = 1'b1;
      end
    endcase
    // Upper bit set wins over the lower one
    next_q.clk_switch = ~mon[1];
    next_q.monitor = (mon == 2'h0);
    next_q.sec_power = bit_of(cw, `CFG_SEC_POWER_BIT);
    next_q.range = cw[`CFG_RANGE_LSB +: 2];
    // Flag only; the reserved code is the programmer's to avoid
    next_q.reserved = (range_t'(cw[`CFG_RANGE_LSB +: 2]) == RANGE_RESERVED);
    next_q.clk_out = bit_of(cw, `CFG_CLKOUT_BIT) &&
      (pmode == PRI_OFF || pmode == PRI_EXTERNAL);
    next_q.pri_en = (pmode != PRI_OFF);
    next_q.hs = (pmode == PRI_HIGH_SPEED);
    next_q.xt = (pmode == PRI_STANDARD);
    next_q.ec = (pmode == PRI_EXTERNAL);
  end

  // Reset shows the erased-word decode: all ones except unused bits
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      q <= '{valid: 1'b0, switchover: 1'b1, slow_rc_pwr: 1'b1,
        sec_crystal: 1'b1, src: 3'h7, pll: 1'b0, postscale: 1'b1,
        clk_switch: 1'b0, monitor: 1'b0, sec_power: 1'b1,
        range: 2'h3, reserved: 1'b0, clk_out: 1'b1, pri_en: 1'b0,
        hs: 1'b0, xt: 1'b0, ec: 1'b0};
    end else begin
      q <= next_q;
    end
  end

  // ***********************************************************
  // Outputs
  // ***********************************************************
  assign SEL_WORD_READ = sw;
  assign CFG_WORD_READ = cw;
  assign CONFIG_VALID = q.valid;
  assign TWO_SPEED_SWITCHOVER_EN = q.switchover;
  assign SLOW_RC_POWER_SELECT = q.slow_rc_pwr;
  assign SECONDARY_CRYSTAL_EN = q.sec_crystal;
  assign SECONDARY_DIGITAL_CLOCK_IN_EN = ~q.sec_crystal;
  assign STARTUP_SOURCE_FIELD = q.src;
  assign USE_PLL = q.pll;
  assign USE_POSTSCALER = q.postscale;
  assign CLOCK_SWITCH_EN = q.clk_switch;
  assign FAIL_SAFE_MONITOR_EN = q.monitor;
  assign SECONDARY_POWER_SELECT = q.sec_power;
  assign PRIMARY_RANGE_FIELD = q.range;
  assign RANGE_RESERVED_SEEN = q.reserved;
  assign CLOCK_OUTPUT_EN = q.clk_out;
  assign PRIMARY_OSC_EN = q.pri_en;
  assign HIGH_SPEED_CRYSTAL_MODE = q.hs;
  assign STANDARD_CRYSTAL_MODE = q.xt;
  assign EXTERNAL_CLOCK_MODE = q.ec;

  // ***********************************************************
  // Checks
  // ***********************************************************
  sequence settled_s;
    q.valid ##1 q.valid;
  endsequence

  switchover_bit_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    settled_s |-> TWO_SPEED_SWITCHOVER_EN == sw[7])
    else $error("switchover mismatch");
  slow_rc_bit_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    settled_s |-> SLOW_RC_POWER_SELECT == sw[6])
    else $error("slow rc power mismatch");
  sec_source_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    settled_s |-> SECONDARY_CRYSTAL_EN != SECONDARY_DIGITAL_CLOCK_IN_EN
    && SECONDARY_CRYSTAL_EN == sw[5])
    else $error("secondary source mismatch");
  unused_zero_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    SEL_WORD_READ[4:3] == 2'h0)
    else $error("unused selection bits not zero");
  pll_low_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    settled_s |-> USE_PLL == (sw[2:0] == 3'h1 || sw[2:0] == 3'h3))
    else $error("pll use mismatch");
  divider_use_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    settled_s |-> USE_POSTSCALER ==
    (sw[2:0] == 3'h1 || sw[2:0] == 3'h6 || sw[2:0] == 3'h7))
    else $error("postscaler mismatch");
  monitor_pair_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    settled_s |-> CLOCK_SWITCH_EN == !cw[7]
    && FAIL_SAFE_MONITOR_EN == (cw[7:6] == 2'h0))
    else $error("monitor decode mismatch");
  sec_power_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    settled_s |-> SECONDARY_POWER_SELECT == cw[5])
    else $error("secondary power mismatch");
  range_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    settled_s |-> PRIMARY_RANGE_FIELD == cw[4:3]
    && RANGE_RESERVED_SEEN == (cw[4:3] == 2'h0))
    else $error("range mismatch");
  clock_out_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    settled_s |-> CLOCK_OUTPUT_EN ==
    (cw[2] && (cw[1:0] == 2'h3 || cw[1:0] == 2'h0)))
    else $error("clock out decode mismatch");
  mode_onehot_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    settled_s |-> $countones({HIGH_SPEED_CRYSTAL_MODE, STANDARD_CRYSTAL_MODE,
    EXTERNAL_CLOCK_MODE}) == (PRIMARY_OSC_EN ? 1 : 0)
    && PRIMARY_OSC_EN == (cw[1:0] != 2'h3)
    && HIGH_SPEED_CRYSTAL_MODE == (cw[1:0] == 2'h2)
    && EXTERNAL_CLOCK_MODE == (cw[1:0] == 2'h0))
    else $error("primary mode decode");
  decode_hold_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    settled_s |=> $stable(q))
    else $error("decode changed after capture");
endmodule // osc_config_decode

/* File: shared/osc_cfg_defs.svh */
// Bit positions, unused-bit mask and erased values of the two config words.
// Assumes inclusion by bare name from the decode and capture modules.
`ifndef OSC_CFG_DEFS_SVH
`define OSC_CFG_DEFS_SVH
`define SEL_SWITCHOVER_BIT 7
`define SEL_SLOW_RC_PWR_BIT 6
`define SEL_SEC_SOURCE_BIT 5
`define SEL_UNUSED_MASK 8'h18
`define SEL_STARTUP_LSB 0
`define CFG_MONITOR_LSB 6
`define CFG_SEC_POWER_BIT 5
`define CFG_RANGE_LSB 3
`define CFG_CLKOUT_BIT 2
`define CFG_PRIMARY_LSB 0
`define SEL_ERASED 8'hE7
`define CFG_ERASED 8'hFF
`endif

/* File: shared/osc_cfg_pkg.sv */
// Types for the oscillator configuration decoder.
// Assumes nothing beyond the defines header.
package osc_cfg_pkg;
  typedef enum logic [2:0] {
    SRC_FAST_RC = 3'h0, SRC_FAST_RC_DIV_PLL = 3'h1, SRC_PRIMARY = 3'h2,
    SRC_PRIMARY_PLL = 3'h3, SRC_SECONDARY = 3'h4, SRC_SLOW_RC = 3'h5,
    SRC_LP_FAST_RC_DIV = 3'h6, SRC_FAST_RC_DIV = 3'h7
  } startup_src_t;
  typedef enum logic [1:0] {
    PRI_EXTERNAL = 2'h0, PRI_STANDARD = 2'h1, PRI_HIGH_SPEED = 2'h2,
    PRI_OFF = 2'h3
  } primary_mode_t;
  typedef enum logic [1:0] {
    RANGE_RESERVED = 2'h0, RANGE_LOW = 2'h1, RANGE_MID = 2'h2,
    RANGE_HIGH = 2'h3
  } range_t;
  typedef enum logic [1:0] {
    LATCH_IDLE = 2'h0, LATCH_DONE = 2'h1
  } latch_state_t;
endpackage

/* File: shared/osc_words_if.sv */
// Carries the two latched config words between capture and decode.
// Assumes the capture stage drives, the decode stage only reads.
`timescale 1ns/100ps
interface osc_words_if;
  logic [7:0] sel_word;
  logic [7:0] cfg_word;
  modport source (output sel_word, output cfg_word);
  modport sink (input sel_word, input cfg_word);
endinterface

/* File: logic/osc_word_capture.sv */
// Captures both configuration words once, right after reset release.
// Assumes the words stay stable from the configuration memory.
`timescale 1ns/100ps
`include "osc_cfg_defs.svh"
module osc_word_capture import osc_cfg_pkg::*; (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [7:0] sel_in,
  input wire logic [7:0] cfg_in,
  output logic captured,
  osc_words_if.source words
);
  typedef struct packed {
    latch_state_t st;
    logic [7:0] sel;
    logic [7:0] cfg;
  } cap_t;
  cap_t q;
  cap_t next_q;

  always_comb begin
    next_q = q;
    case (q.st)
      LATCH_IDLE: begin
        // Unused bits forced low on capture
        next_q.sel = sel_in & ~`SEL_UNUSED_MASK;
        next_q.cfg = cfg_in;
        next_q.st = LATCH_DONE;
      end
      LATCH_DONE: next_q = q;
      default: next_q.st = LATCH_IDLE;
    endcase
  end

  // Erased values until the real words are caught
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '{st: LATCH_IDLE, sel: `SEL_ERASED, cfg: `CFG_ERASED};
    end else begin
      q <= next_q;
    end
  end

  assign words.sel_word = q.sel;
  assign words.cfg_word = q.cfg;
  assign captured = (q.st == LATCH_DONE);

  hold_words_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    $past(q.st == LATCH_DONE) |-> $stable(q.sel) && $stable(q.cfg))
    else $error("config words changed after capture");
endmodule // osc_word_capture

/* File: testbench/cfg_memory_model.sv */
// Configuration memory model holding the two oscillator words.
// Assumes the bench writes it through table writes on clock edges.
`timescale 1ns/100ps
module cfg_memory_model (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [23:0] wr_addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] sel_word,
  output logic [7:0] cfg_word
);
  // ****************************************************************
  // Storage
  // ****************************************************************
  // Unprogrammed cells read as one
  logic [7:0] sel_cell = 8'hFF;
  logic [7:0] cfg_cell = 8'hFF;
  // Only table writes to the two word locations land
  always @(posedge clk) begin
    if (wr_en && wr_addr == 24'hF80006)
      sel_cell <= wr_data;
    if (wr_en && wr_addr == 24'hF80008)
      cfg_cell <= wr_data;
  end
  assign sel_word = sel_cell;
  assign cfg_word = cfg_cell;
endmodule // cfg_memory_model

/* File: testbench/osc_config_decode_tb.sv */
// Self-checking bench for the oscillator configuration decoder.
// Assumes capture on the first edge after reset release.
`timescale 1ns/100ps
module osc_config_decode_tb;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic wr_en = 1'b0;
  logic [23:0] wr_addr = 24'h000000;
  logic [7:0] wr_data = 8'h00;
  logic [7:0] sel_word, cfg_word, sel_rd, cfg_rd, s, c;
  logic [2:0] src;
  logic [1:0] rng, r;
  logic vld, swo, slow, xtal, dig, pll, post, swe, fsm, spw;
  logic rres, clock_output, pen, hs, xt, ec;
  int fail_count = 0;
  int n_tests = 0;
  always #10 ref_clk = ~ref_clk;
  cfg_memory_model mem (.clk(ref_clk), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .sel_word(sel_word), .cfg_word(cfg_word));
  osc_config_decode uut (
    .REF_CLK(ref_clk), .ARST_N(arst_n),
    .SEL_WORD_IN(sel_word), .CFG_WORD_IN(cfg_word),
    .SEL_WORD_READ(sel_rd), .CFG_WORD_READ(cfg_rd), .CONFIG_VALID(vld),
    .TWO_SPEED_SWITCHOVER_EN(swo), .SLOW_RC_POWER_SELECT(slow),
    .SECONDARY_CRYSTAL_EN(xtal), .SECONDARY_DIGITAL_CLOCK_IN_EN(dig),
    .STARTUP_SOURCE_FIELD(src), .USE_PLL(pll), .USE_POSTSCALER(post),
    .CLOCK_SWITCH_EN(swe), .FAIL_SAFE_MONITOR_EN(fsm),
    .SECONDARY_POWER_SELECT(spw), .PRIMARY_RANGE_FIELD(rng),
    .RANGE_RESERVED_SEEN(rres), .CLOCK_OUTPUT_EN(clock_output),
    .PRIMARY_OSC_EN(pen), .HIGH_SPEED_CRYSTAL_MODE(hs),
    .STANDARD_CRYSTAL_MODE(xt), .EXTERNAL_CLOCK_MODE(ec));
  // ****************************************************************
  // Compare and access tasks
  // ****************************************************************
  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tbl_write(input logic [23:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    wr_en = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(posedge ref_clk);
    #1;
    wr_en = 1'b0;
  endtask
  task automatic restart(input int n);
    @(posedge ref_clk);
    #1;
    arst_n = 1'b0;
    repeat (n) @(posedge ref_clk);
    #1;
    chk_bit(vld, 1'b0);
    chk_word(sel_rd, 8'hE7);
    chk_word(cfg_rd, 8'hFF);
    arst_n = 1'b1;
    @(posedge ref_clk);
    #1;
    chk_word(sel_rd, s & 8'hE7);
    chk_bit(vld, 1'b0);
    @(posedge ref_clk);
    #1;
  endtask
  task automatic check_decode;
    logic [1:0] m;
    m = c[1:0];
    chk_bit(vld, 1'b1);
    chk_word(sel_rd, s & 8'hE7);
    chk_word(cfg_rd, c);
    chk_bit(swo, s[7]);
    chk_bit(slow, s[6]);
    chk_bit(xtal, s[5]);
    chk_bit(dig, ~s[5]);
    chk_word({5'h00, src}, {5'h00, s[2:0]});
    chk_bit(pll, s[2:0] == 3'h1 || s[2:0] == 3'h3);
    chk_bit(post, s[2:0] == 3'h1 || s[2:0] >= 3'h6);
    chk_bit(swe, ~c[7]);
    chk_bit(fsm, c[7:6] == 2'h0);
    chk_bit(spw, c[5]);
    chk_word({6'h00, rng}, {6'h00, c[4:3]});
    chk_bit(rres, c[4:3] == 2'h0);
    chk_bit(clock_output, c[2] && (m == 2'h3 || m == 2'h0));
    chk_bit(pen, m != 2'h3);
    chk_bit(hs, m == 2'h2);
    chk_bit(xt, m == 2'h1);
    chk_bit(ec, m == 2'h0);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    s = 8'hFF;
    c = 8'hFF;
    restart(16);
    check_decode;
    $display("test erased words done");
    for (int i = 0; i < 8; i++) begin
      // Range code 00 is never programmed
      r = 2'(i % 3 + 1);
      s = {i[0], ~i[0], i[1], 2'h3, i[2:0]};
      c = {i[2:1], i[0], r, i[2], i[1:0]};
      tbl_write(24'hF80006, s);
      tbl_write(24'hF80008, c);
      restart(2);
      check_decode;
      // Reprogramming while running must not reach the outputs
      tbl_write(24'hF80006, ~s);
      tbl_write(24'hF80008, c ^ 8'hE4);
      repeat (3) @(posedge ref_clk);
      #1;
      check_decode;
      $display("test word set %0d done", i);
    end
    test_done;
  end
  initial begin
    repeat (2000) @(posedge ref_clk);
    fail_count++;
    test_done;
  end
endmodule // osc_config_decode_tb
